// File: squib_arming_deploy_control.sv
/*
  Deployment-permission logic for eight squib loops: arming serial port,
  deployment serial port, per-channel stretch timers, firing timers,
  enable-pin deglitch and driver outputs.
  Assumes serial pins and the enable pin are asynchronous to sys_clk_i and
  that each serial clock is far slower than the system clock.
*/
`timescale 1ns/100ps

module squib_arming_deploy_control
  import squib_arm_pkg::*;
#(
  parameter int CH = NUM_CH,
  parameter int TMR_W = 21,
  parameter int STRETCH_CYCLES = STRETCH_CYC,
  parameter int FIRE_CYCLES = FIRE_CYC,
  parameter int DEGLITCH_CYCLES = DEGLITCH_CYC,
  parameter int DIAG_CYCLES = DIAG_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic fire_permit_pin_i,
  input wire logic dep_cs_n_i,
  input wire logic dep_sclk_i,
  input wire logic dep_mosi_i,
  output logic dep_miso_o,
  output logic dep_miso_oe_n_o,
  input wire logic arm_cs_n_i,
  input wire logic arm_sclk_i,
  input wire logic arm_mosi_i,
  output logic arm_miso_o,
  output logic arm_miso_oe_n_o,
  output logic [CH-1:0] loop_high_side_driver_o,
  output logic [CH-1:0] loop_low_side_driver_o,
  output logic [CH-1:0] deploy_success_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: stage 1 feeds stage 2 only, stage 3 is for edges

  spi_in_t dep_s1_reg, dep_s2_reg, dep_s3_reg;
  spi_in_t arm_s1_reg, arm_s2_reg, arm_s3_reg;
  logic pin_s1_reg, pin_s2_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      dep_s1_reg <= SPI_IDLE;
      dep_s2_reg <= SPI_IDLE;
      dep_s3_reg <= SPI_IDLE;
      arm_s1_reg <= SPI_IDLE;
      arm_s2_reg <= SPI_IDLE;
      arm_s3_reg <= SPI_IDLE;
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
    end
    else
    begin
      dep_s1_reg <= '{cs_n: dep_cs_n_i, sclk: dep_sclk_i, mosi: dep_mosi_i};
      dep_s2_reg <= dep_s1_reg;
      dep_s3_reg <= dep_s2_reg;
      arm_s1_reg <= '{cs_n: arm_cs_n_i, sclk: arm_sclk_i, mosi: arm_mosi_i};
      arm_s2_reg <= arm_s1_reg;
      arm_s3_reg <= arm_s2_reg;
      pin_s1_reg <= fire_permit_pin_i;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable pin deglitch

  logic pin_filt_reg;
  logic [15:0] pin_cnt_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      pin_filt_reg <= 1'b0;
      pin_cnt_reg <= 16'h0000;
    end
    else if (pin_s2_reg == pin_filt_reg)
      pin_cnt_reg <= 16'h0000;
    else if (pin_cnt_reg == 16'(DEGLITCH_CYCLES - 1))
    begin
      pin_filt_reg <= pin_s2_reg;
      pin_cnt_reg <= 16'h0000;
    end
    else
      pin_cnt_reg <= pin_cnt_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame edges of both serial ports

  logic dep_sel, dep_begin, dep_end, dep_rise, dep_fall;
  logic arm_sel, arm_begin, arm_end, arm_rise, arm_fall;

  assign dep_sel = !dep_s2_reg.cs_n;
  assign dep_begin = dep_sel && dep_s3_reg.cs_n;
  assign dep_end = !dep_sel && !dep_s3_reg.cs_n;
  assign dep_rise = dep_sel && dep_s2_reg.sclk && !dep_s3_reg.sclk;
  assign dep_fall = dep_sel && !dep_s2_reg.sclk && dep_s3_reg.sclk;
  assign arm_sel = !arm_s2_reg.cs_n;
  assign arm_begin = arm_sel && arm_s3_reg.cs_n;
  assign arm_end = !arm_sel && !arm_s3_reg.cs_n;
  assign arm_rise = arm_sel && arm_s2_reg.sclk && !arm_s3_reg.sclk;
  assign arm_fall = arm_sel && !arm_s2_reg.sclk && arm_s3_reg.sclk;

  logic [CH-1:0] firing, dep_window, arm_window;
  logic any_firing;
  assign any_firing = |firing;

  ////////////////////////////////////////////////////////////////////////////
  // Deployment port: one shift register carries the reply out and the
  // message in, so the last 16 bits received sit in it at negation

  logic [DEP_BITS-1:0] dep_sh_reg, dep_reply_reg, dep_reply_next;
  logic [4:0] dep_cnt_reg;
  logic dep_miso_reg, dep_oe_n_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      dep_sh_reg <= '0;
      dep_cnt_reg <= 5'h00;
      dep_miso_reg <= 1'b0;
      dep_oe_n_reg <= 1'b1;
      dep_reply_reg <= RSP_RESET;
    end
    else
    begin
      dep_oe_n_reg <= !dep_sel;
      if (dep_begin)
      begin
        dep_sh_reg <= dep_reply_reg;
        dep_cnt_reg <= 5'h00;
        dep_miso_reg <= dep_reply_reg[DEP_BITS-1];
      end
      else
      begin
        if (dep_rise)
        begin
          dep_sh_reg <= {dep_sh_reg[DEP_BITS-2:0], dep_s2_reg.mosi};
          if (dep_cnt_reg != DEP_CNT_MAX)
            dep_cnt_reg <= dep_cnt_reg + 5'h01;
        end
        if (dep_fall)
          dep_miso_reg <= dep_sh_reg[DEP_BITS-1];
      end
      if (dep_end)
        dep_reply_reg <= dep_reply_next;
    end
  end

  // Message decode at negation; acts only when the frame length is right
  logic [CH-1:0] dep_start, dep_cancel, diag_req;
  logic [1:0] dep_mode;
  logic [CH-1:0] dep_bits;
  logic [CH-1:0] success_reg;

  assign dep_mode = dep_sh_reg[MODE_MSB:MODE_LSB];
  assign dep_bits = dep_sh_reg[CH-1:0];

  always_comb
  begin
    dep_start = '0;
    dep_cancel = '0;
    diag_req = '0;
    dep_reply_next = RSP_FAULT;
    if (dep_end && dep_cnt_reg == DEP_FRAME_EDGES)
    begin
      case (dep_mode)
        MODE_REGISTER:
        begin
          if (!any_firing)
            dep_reply_next = {RSP_REGISTER, dep_sh_reg[12:0]};
        end
        MODE_COMMAND:
        begin
          // Firing channels are masked off; others keep working
          if (pin_filt_reg)
            dep_start = dep_bits & ~firing;
          dep_cancel = ~dep_bits & ~firing;
          dep_reply_next = {RSP_COMMAND, 5'h00, dep_bits};
        end
        MODE_DIAG:
        begin
          if (!any_firing)
          begin
            diag_req = dep_bits;
            // Requested channels report a failed check while enable is low
            dep_reply_next = {RSP_DIAG, 5'h00, pin_filt_reg ? 8'h00 : dep_bits};
          end
        end
        MODE_MONITOR:
          dep_reply_next = {RSP_STATUS, 5'h00, success_reg};
        default:
          dep_reply_next = RSP_FAULT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arming port: first byte out is the arming status, then the bits
  // received pass straight through, which gives the daisy chain

  logic [ARM_BITS-1:0] arm_sh_reg;
  logic [2:0] arm_cnt_reg;
  logic arm_any_reg, arm_miso_reg, arm_oe_n_reg;
  logic [CH-1:0] arm_start, arm_cancel;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      arm_sh_reg <= '0;
      arm_cnt_reg <= 3'h0;
      arm_any_reg <= 1'b0;
      arm_miso_reg <= 1'b0;
      arm_oe_n_reg <= 1'b1;
    end
    else
    begin
      arm_oe_n_reg <= !arm_sel;
      if (arm_begin)
      begin
        arm_sh_reg <= arm_window;
        arm_cnt_reg <= 3'h0;
        arm_any_reg <= 1'b0;
        arm_miso_reg <= arm_window[ARM_BITS-1];
      end
      else
      begin
        if (arm_rise)
        begin
          arm_sh_reg <= {arm_sh_reg[ARM_BITS-2:0], arm_s2_reg.mosi};
          arm_cnt_reg <= arm_cnt_reg + 3'h1;
          arm_any_reg <= 1'b1;
        end
        if (arm_fall)
          arm_miso_reg <= arm_sh_reg[ARM_BITS-1];
      end
    end
  end

  // Latched only on whole bytes and never while a channel fires
  always_comb
  begin
    arm_start = '0;
    arm_cancel = '0;
    if (arm_end && arm_any_reg && arm_cnt_reg == 3'h0 && !any_firing)
    begin
      arm_start = arm_sh_reg;
      arm_cancel = ~arm_sh_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel stretch, firing and diagnostic timers

  logic [CH-1:0] fire_go, diag_on, hs_reg, ls_reg;

  generate
    for (genvar i = 0; i < CH; i++)
    begin : g_ch
      logic [TMR_W-1:0] arm_tmr_reg, dep_tmr_reg, fire_tmr_reg, diag_tmr_reg;

      assign arm_window[i] = arm_tmr_reg != '0;
      assign dep_window[i] = dep_tmr_reg != '0;
      assign firing[i] = fire_tmr_reg != '0;
      assign diag_on[i] = diag_tmr_reg != '0;
      assign fire_go[i] = pin_filt_reg && !firing[i] &&
        ((dep_start[i] && arm_window[i]) || (arm_start[i] && dep_window[i]));

      // Timers never look at the enable pin once running
      always_ff @(posedge sys_clk_i)
      begin
        if (reset_i)
          arm_tmr_reg <= '0;
        else if (arm_start[i])
          arm_tmr_reg <= TMR_W'(STRETCH_CYCLES);
        else if (arm_cancel[i])
          arm_tmr_reg <= '0;
        else if (arm_window[i])
          arm_tmr_reg <= arm_tmr_reg - 1'b1;
      end

      always_ff @(posedge sys_clk_i)
      begin
        if (reset_i)
          dep_tmr_reg <= '0;
        else if (dep_start[i])
          dep_tmr_reg <= TMR_W'(STRETCH_CYCLES);
        else if (dep_cancel[i])
          dep_tmr_reg <= '0;
        else if (dep_window[i])
          dep_tmr_reg <= dep_tmr_reg - 1'b1;
      end

      // Nothing but reset can cut a firing short
      always_ff @(posedge sys_clk_i)
      begin
        if (reset_i)
          fire_tmr_reg <= '0;
        else if (fire_go[i])
          fire_tmr_reg <= TMR_W'(FIRE_CYCLES);
        else if (firing[i])
          fire_tmr_reg <= fire_tmr_reg - 1'b1;
      end

      always_ff @(posedge sys_clk_i)
      begin
        if (reset_i)
          success_reg[i] <= 1'b0;
        else if (fire_tmr_reg == TMR_W'(1))
          success_reg[i] <= 1'b1;
      end

      // Diagnostic runs its time even with enable low, but drives nothing then
      always_ff @(posedge sys_clk_i)
      begin
        if (reset_i)
          diag_tmr_reg <= '0;
        else if (diag_req[i] && !firing[i])
          diag_tmr_reg <= TMR_W'(DIAG_CYCLES);
        else if (diag_on[i])
          diag_tmr_reg <= diag_tmr_reg - 1'b1;
      end

      always_ff @(posedge sys_clk_i)
      begin
        if (reset_i)
        begin
          hs_reg[i] <= 1'b0;
          ls_reg[i] <= 1'b0;
        end
        else
        begin
          hs_reg[i] <= firing[i] || (diag_on[i] && pin_filt_reg);
          ls_reg[i] <= firing[i] || (diag_on[i] && pin_filt_reg);
        end
      end
    end
  endgenerate

  assign dep_miso_o = dep_miso_reg;
  assign dep_miso_oe_n_o = dep_oe_n_reg;
  assign arm_miso_o = arm_miso_reg;
  assign arm_miso_oe_n_o = arm_oe_n_reg;
  assign loop_high_side_driver_o = hs_reg;
  assign loop_low_side_driver_o = ls_reg;
  assign deploy_success_o = success_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_oe_follows_cs: assert property (dep_miso_oe_n_o == !$past(dep_sel))
    else $error("deployment output enable does not follow chip select");

  a_fire_held: assert property ($rose(firing[0]) |=> firing[0] [*8])
    else $error("firing ended early");

  a_success_set: assert property ($fell(firing[0]) |-> success_reg[0])
    else $error("success flag missing after firing");

  a_drivers_cause: assert property ((hs_reg & ~$past(firing | diag_on)) == '0)
    else $error("driver on without firing or diagnostic");

  // Watched on the timer itself, so a wrong gate on the latch strobe shows
  a_arm_ignored_fire: assert property (any_firing |=>
      g_ch[0].arm_tmr_reg == ($past(g_ch[0].arm_tmr_reg) == '0 ?
      '0 : $past(g_ch[0].arm_tmr_reg) - 1'b1))
    else $error("arming request acted on during firing");

  a_pin_low_start: assert property (!pin_filt_reg |=>
      g_ch[0].dep_tmr_reg <= $past(g_ch[0].dep_tmr_reg))
    else $error("deployment command started timer with enable low");

  a_deglitch_hold: assert property ($changed(pin_filt_reg) |->
      $past(pin_s2_reg, 1) == pin_filt_reg && $past(pin_s2_reg, 4) == pin_filt_reg)
    else $error("enable filter passed a short pulse");

  a_bad_count_fault: assert property (dep_end && dep_cnt_reg != DEP_FRAME_EDGES |=>
      dep_reply_reg == RSP_FAULT)
    else $error("bad frame length without fault reply");

  a_fire_needs_pin: assert property ($rose(firing[0]) |-> $past(pin_filt_reg))
    else $error("firing started with enable low");

  c_fire_start: cover property ($rose(firing[0]));
  c_arm_latch: cover property (arm_start != '0);
  c_dep_fault: cover property (dep_end && dep_cnt_reg != DEP_FRAME_EDGES);

endmodule

// File: squib_arm_pkg.sv
/*
  Shared constants and types for the squib deployment-permission logic:
  serial frame sizes, reply mode codes and the timing constants.
  Assumes a single 250 MHz system clock drives all logic.
*/
package squib_arm_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int NUM_CH = 8;

  // Times as specified, then cycle counts (least times rounded up)
  localparam int STRETCH_TIME_US = 4000;
  localparam int FIRE_TIME_US = 2000;
  localparam int DEGLITCH_TIME_NS = 2000;
  localparam int DIAG_TIME_US = 100;
  localparam int STRETCH_CYC = (STRETCH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRE_CYC = (FIRE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEGLITCH_CYC = (DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIAG_CYC = (DIAG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Deployment and arming port frames and deployment mode field
  localparam int DEP_BITS = 16;
  localparam int ARM_BITS = 8;
  localparam logic [4:0] DEP_FRAME_EDGES = 5'h10;
  localparam logic [4:0] DEP_CNT_MAX = 5'h1f;
  localparam int MODE_MSB = 15;
  localparam int MODE_LSB = 14;

  localparam logic [1:0] MODE_REGISTER = 2'h0;
  localparam logic [1:0] MODE_COMMAND = 2'h1;
  localparam logic [1:0] MODE_DIAG = 2'h2;
  localparam logic [1:0] MODE_MONITOR = 2'h3;

  // Reply headers (mode bits and fault bit D13)
  localparam logic [2:0] RSP_REGISTER = 3'h0;
  localparam logic [2:0] RSP_COMMAND = 3'h2;
  localparam logic [2:0] RSP_DIAG = 3'h4;
  localparam logic [2:0] RSP_STATUS = 3'h6;
  localparam logic [15:0] RSP_FAULT = 16'he000;
  localparam logic [15:0] RSP_RESET = 16'h0000;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } spi_in_t;

  localparam spi_in_t SPI_IDLE = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};

endpackage

// File: host_spi_model.sv
/*
  Host controller model: drives the deployment and arming serial ports as a
  bus master, MSB first, data changed on the falling clock edge.
  Assumes the device answers on its own miso pins with low-active enables.
*/
`timescale 1ns/100ps

module host_spi_model
  import squib_arm_pkg::*;
(
  input wire logic dep_miso_i,
  input wire logic dep_miso_oe_n_i,
  input wire logic arm_miso_i,
  input wire logic arm_miso_oe_n_i,
  output spi_in_t dep_o,
  output spi_in_t arm_o
);
  localparam realtime HALF = 62.5;
  logic last_bit = 1'b0;

  initial
  begin
    dep_o = SPI_IDLE;
    arm_o = SPI_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic arm, input spi_in_t b);
    if (arm)
      arm_o = b;
    else
      dep_o = b;
  endtask

  // Clock stands low outside frames; released miso reads as inverted last bit
  task automatic xfer(input logic arm, input int n, input logic [15:0] tx,
                      output logic [15:0] rx);
    spi_in_t b;
    logic oe_n;
    logic d;
    b = SPI_IDLE;
    rx = 16'h0000;
    b.cs_n = 1'b0;
    put(arm, b);
    #HALF;
    for (int i = n - 1; i >= 0; i--)
    begin
      b.mosi = tx[i];
      put(arm, b);
      #HALF;
      b.sclk = 1'b1;
      put(arm, b);
      oe_n = arm ? arm_miso_oe_n_i : dep_miso_oe_n_i;
      d = arm ? arm_miso_i : dep_miso_i;
      last_bit = oe_n ? ~last_bit : d;
      rx = {rx[14:0], last_bit};
      #HALF;
      b.sclk = 1'b0;
      put(arm, b);
    end
    #HALF;
    put(arm, SPI_IDLE);
    // Gap covers the select-negated minimum and the decode latency
    #200;
  endtask
endmodule

// File: tb_top.sv
/*
  Testbench for the squib deployment-permission logic: serial frames from the
  host model with expected replies and driver behaviour.
  Assumes shortened timer parameters so the run stays short.
*/
`timescale 1ns/100ps

module tb_top;
  import squib_arm_pkg::*;
  localparam int STR = 10000;
  localparam int FIR = 3000;
  localparam int DGL = 8;
  localparam int DIAG = 200;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic pin = 1'b0;
  logic hs_clr = 1'b0;
  spi_in_t dep_bus;
  spi_in_t arm_bus;
  logic dep_miso;
  logic dep_oe_n;
  logic arm_miso;
  logic arm_oe_n;
  logic [7:0] hs;
  logic [7:0] ls;
  logic [7:0] ok;
  logic [15:0] rx;
  int fail_count = 0;
  int check_count = 0;
  int hs_cnt = 0;

  squib_arming_deploy_control #(.STRETCH_CYCLES(STR), .FIRE_CYCLES(FIR),
    .DEGLITCH_CYCLES(DGL), .DIAG_CYCLES(DIAG)) squib_arming_deploy_control_inst (
    .sys_clk_i(sys_clk), .reset_i(reset), .fire_permit_pin_i(pin),
    .dep_cs_n_i(dep_bus.cs_n), .dep_sclk_i(dep_bus.sclk), .dep_mosi_i(dep_bus.mosi),
    .dep_miso_o(dep_miso), .dep_miso_oe_n_o(dep_oe_n),
    .arm_cs_n_i(arm_bus.cs_n), .arm_sclk_i(arm_bus.sclk), .arm_mosi_i(arm_bus.mosi),
    .arm_miso_o(arm_miso), .arm_miso_oe_n_o(arm_oe_n),
    .loop_high_side_driver_o(hs), .loop_low_side_driver_o(ls), .deploy_success_o(ok));

  host_spi_model host_spi_model_inst (
    .dep_miso_i(dep_miso), .dep_miso_oe_n_i(dep_oe_n),
    .arm_miso_i(arm_miso), .arm_miso_oe_n_i(arm_oe_n),
    .dep_o(dep_bus), .arm_o(arm_bus));

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  // Cycles any high-side driver stays on, cleared before each firing
  always @(posedge sys_clk)
  begin
    if (hs_clr)
      hs_cnt <= 0;
    else if ((|hs) === 1'b1)
      hs_cnt <= hs_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic dep(input logic [15:0] tx);
    host_spi_model_inst.xfer(1'b0, 16, tx, rx);
  endtask

  task automatic arm(input logic [7:0] tx);
    host_spi_model_inst.xfer(1'b1, 8, {8'h00, tx}, rx);
  endtask

  task automatic set_pin(input logic v);
    step(1);
    pin = v;
    step(DGL + 6);
  endtask

  // Bounded wait for a driver pattern to appear
  task automatic fire_wait(input logic [7:0] exp);
    for (int i = 0; i < 40 && hs !== exp; i++)
      step(1);
    chk("high side", {8'h00, exp}, {8'h00, hs});
  endtask

  task automatic fire_end();
    for (int i = 0; i < FIR + 100 && hs !== 8'h00; i++)
      step(1);
  endtask

  task automatic tend(input string name);
    $display("Test %s done", name);
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    // Tests need about 62 us; this leaves more than twice that
    #150us;
    fail_count++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(12);
    reset = 1'b0;
    step(4);
    chk("drivers", 16'h0000, {hs, ls});
    chk("oe_n", 16'h0003, {14'h0000, dep_oe_n, arm_oe_n});
    chk("success", 16'h0000, {8'h00, ok});
    tend("reset");

    arm(8'h01);
    chk("arm status", 16'h0000, {8'h00, rx[7:0]});
    // Diagnostic keeps running with the pin low, so a passed glitch would light it
    dep(16'h8001);
    chk("reset reply", 16'h0000, rx);
    hs_clr = 1'b1;
    step(1);
    hs_clr = 1'b0;
    pin = 1'b1;
    step(4);
    pin = 1'b0;
    step(DGL + 6);
    chk("glitch drivers", 16'h0000, hs_cnt[15:0]);
    dep(16'h4001);
    chk("diag reply", 16'h8001, rx);
    step(20);
    chk("drivers", 16'h0000, {hs, ls});
    dep(16'hc000);
    chk("cmd echo", 16'h4001, rx);
    tend("pin low");

    set_pin(1'b1);
    hs_clr = 1'b1;
    step(1);
    hs_clr = 1'b0;
    dep(16'h4001);
    chk("status reply", 16'hc000, rx);
    fire_wait(8'h01);
    chk("low side", 16'h0001, {8'h00, ls});
    set_pin(1'b0);
    arm(8'h00);
    dep(16'h0000);
    dep(16'hc000);
    chk("register in fire", 16'he000, rx);
    chk("drivers", 16'h0101, {hs, ls});
    fire_end();
    chk("fire length", FIR[15:0], hs_cnt[15:0]);
    chk("success", 16'h0001, {8'h00, ok});
    tend("fire");

    dep(16'hc000);
    chk("status reply", 16'hc000, rx);
    dep(16'hc000);
    chk("status reply", 16'hc001, rx);
    arm(8'h00);
    chk("arm status", 16'h0001, {8'h00, rx[7:0]});
    arm(8'h00);
    chk("arm status", 16'h0000, {8'h00, rx[7:0]});
    tend("status");

    host_spi_model_inst.xfer(1'b0, 12, 16'h0123, rx);
    dep(16'hc000);
    chk("short frame", 16'he000, rx);
    host_spi_model_inst.xfer(1'b1, 4, 16'h0001, rx);
    arm(8'h00);
    chk("arm status", 16'h0000, {8'h00, rx[7:0]});
    tend("counts");

    set_pin(1'b1);
    hs_clr = 1'b1;
    step(1);
    hs_clr = 1'b0;
    dep(16'h8004);
    chk("status reply", 16'hc001, rx);
    step(DIAG);
    chk("diag length", DIAG[15:0], hs_cnt[15:0]);
    dep(16'h4002);
    chk("diag reply", 16'h8000, rx);
    dep(16'h4000);
    arm(8'h02);
    step(20);
    chk("drivers", 16'h0000, {hs, ls});
    arm(8'h00);
    hs_clr = 1'b1;
    dep(16'h4002);
    hs_clr = 1'b0;
    chk("drivers", 16'h0000, {hs, ls});
    arm(8'h02);
    fire_wait(8'h02);
    fire_end();
    chk("fire length", FIR[15:0], hs_cnt[15:0]);
    chk("success", 16'h0003, {8'h00, ok});
    tend("windows");
    wrap_up();
  end
endmodule
